// file: hdl/ssrc_top.sv
// start/restart sequencer of the safety relay: mode detection, timing, output control
// ============================================================
module ssrc_top
    import ssrc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = SSRC_TICK_CYCLES
)
(
    input  wire logic  sys_clk,
    input  wire logic  sys_rst,
    input  wire logic  safety_supply_input_pos,
    input  wire logic  auto_manual_start_input,
    input  wire logic  monitored_start_input,
    output logic       start_supply_output,
    output logic       safety_outputs_energized,
    output logic       fault_latched,
    output ssrc_mode_t start_mode
);

    // ============================================================
    // state
    typedef struct packed {
        ssrc_run_t                  run;
        ssrc_mode_t                 mode;
        logic [SSRC_PRESC_W-1:0]    presc;
        logic                       tick;
        logic [SSRC_UPTIME_W-1:0]   uptime_ms;
        logic [SSRC_PULSE_W-1:0]    pulse_ms;
        logic                       am_prev;
        logic                       mon_prev;
        logic                       out_on;
        logic                       fault;
        logic                       supply_out;
    } ssrc_state_t;

    ssrc_state_t q;
    ssrc_state_t d;
    ssrc_pins_t  pins_raw;
    ssrc_pins_t  pins;

    localparam logic [SSRC_UPTIME_W-1:0] WAIT_MS   = SSRC_UPTIME_W'(SSRC_POWER_ON_WAIT_MS);
    localparam logic [SSRC_UPTIME_W-1:0] DETECT_MS = SSRC_UPTIME_W'(SSRC_AUTO_DETECT_MS);
    localparam logic [SSRC_PULSE_W-1:0]  MIN_MS    = SSRC_PULSE_W'(SSRC_MIN_PULSE_MS);
    localparam logic [SSRC_PRESC_W-1:0]  TICK_LAST = SSRC_PRESC_W'(TICK_CYCLES - 1);

    // ============================================================
    // pin conditioning
    // every pin is asynchronous to sys_clk, so all three pass the filter
    assign pins_raw = '{supply:    safety_supply_input_pos,
                        am_start:  auto_manual_start_input,
                        mon_start: monitored_start_input};

    ssrc_sync u_sync (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .pins_raw   (pins_raw),
        .pins_clean (pins)
    );

    // ============================================================
    // sequencing
    logic       am_rise;
    logic       qualified;
    logic       cross_wired;
    logic       both_on;
    logic       mon_misuse;
    logic       am_misuse;
    logic       detected;
    ssrc_mode_t mode_eff;

    always_comb begin
        d         = q;
        // am_prev resets low, so a tied-high channel shows one rise; power-up masks it
        am_rise   = pins.am_start && !q.am_prev;
        // modes are read only once the inputs have settled after power-on
        detected  = q.uptime_ms >= DETECT_MS;
        // falling edge after at least the minimum high time; shorter pulses vanish
        qualified = q.mon_prev && !pins.mon_start && (q.pulse_ms >= MIN_MS);
        // the selecting press also starts the relay, so the new mode is used at once
        mode_eff  = q.mode;

        // ============================================================
        // timing counters
        // fixed-period tick drives every delay count
        d.tick = 1'b0;
        if (q.presc == TICK_LAST) begin
            d.presc = '0;
            d.tick  = 1'b1;
        end else begin
            d.presc = q.presc + SSRC_PRESC_W'(1);
        end

        if (q.tick && (q.uptime_ms < WAIT_MS)) begin
            d.uptime_ms = q.uptime_ms + SSRC_UPTIME_W'(1);
        end

        // width counter saturates at the minimum; cleared once the input is low
        if (!pins.mon_start) begin
            d.pulse_ms = '0;
        end else if (q.tick && (q.pulse_ms < MIN_MS)) begin
            d.pulse_ms = q.pulse_ms + SSRC_PULSE_W'(1);
        end

        d.am_prev  = pins.am_start;
        d.mon_prev = pins.mon_start;

        // ============================================================
        // mode detection
        // the auto/manual channel tied high at detection time means automatic, else first use decides
        if (detected && (q.mode == SSRC_MODE_NONE)) begin
            if (pins.am_start && !am_rise) begin
                mode_eff = SSRC_MODE_AUTO;
            end else if (am_rise) begin
                mode_eff = SSRC_MODE_MANUAL;
            end else if (pins.mon_start) begin
                mode_eff = SSRC_MODE_MONITORED;
            end
        end
        d.mode = mode_eff;

        // both channels in use is a wiring error
        both_on     = pins.am_start && pins.mon_start;
        mon_misuse  = pins.mon_start && (q.mode == SSRC_MODE_AUTO
                                      || q.mode == SSRC_MODE_MANUAL);
        am_misuse   = pins.am_start && (q.mode == SSRC_MODE_MONITORED);
        cross_wired = both_on || mon_misuse || am_misuse;

        // ============================================================
        // run state
        case (q.run)
            SSRC_ST_POWER_UP: begin
                if (detected) begin
                    d.run = SSRC_ST_DEENERGIZED;
                end
            end
            SSRC_ST_DEENERGIZED: begin
                if (pins.supply) begin
                    case (mode_eff)
                        SSRC_MODE_AUTO: begin
                            d.run = SSRC_ST_ENERGIZED;
                        end
                        SSRC_MODE_MANUAL: begin
                            if (am_rise) begin
                                d.run = SSRC_ST_ENERGIZED;
                            end
                        end
                        SSRC_MODE_MONITORED: begin
                            // starts before the power-on wait has run out are ignored
                            if (qualified && (q.uptime_ms >= WAIT_MS)) begin
                                d.run = SSRC_ST_ENERGIZED;
                            end
                        end
                        default: begin
                            d.run = SSRC_ST_DEENERGIZED;
                        end
                    endcase
                end
            end
            SSRC_ST_ENERGIZED: begin
                if (!pins.supply) begin
                    d.run = SSRC_ST_DEENERGIZED;
                end
            end
            SSRC_ST_FAULT: begin
                // no way out of here short of a power cycle
                d.run = SSRC_ST_FAULT;
            end
            default: begin
                d.run = SSRC_ST_FAULT;
            end
        endcase

        // only a new reset leaves the fault state
        if (cross_wired || q.fault) begin
            d.run   = SSRC_ST_FAULT;
            d.fault = 1'b1;
        end

        // registered from the next state, so outputs carry no extra cycle of lag
        d.out_on     = (d.run == SSRC_ST_ENERGIZED);
        // a bridged automatic channel falls with the start supply in fault
        d.supply_out = !d.fault;
    end

    // sys_rst stands for power-on: counters, mode and fault start afresh
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= '{run:        SSRC_ST_POWER_UP,
                   mode:       SSRC_MODE_NONE,
                   presc:      '0,
                   tick:       1'b0,
                   uptime_ms:  '0,
                   pulse_ms:   '0,
                   am_prev:    1'b0,
                   mon_prev:   1'b0,
                   out_on:     1'b0,
                   fault:      1'b0,
                   supply_out: 1'b0};
        end else begin
            q <= d;
        end
    end

    // ============================================================
    // outputs, all straight from the state register
    assign start_supply_output      = q.supply_out;
    assign safety_outputs_energized = q.out_on;
    assign fault_latched            = q.fault;
    assign start_mode               = q.mode;

endmodule

// file: hdl/ssrc_pkg.sv
// constants, modes, states and pin carrier of the start/restart sequencer
package ssrc_pkg;

    // ============================================================
    // clock and tick
    localparam int unsigned SSRC_CLK_PERIOD_NS = 40;
    localparam int unsigned SSRC_TICK_NS       = 1_000_000;
    localparam int unsigned SSRC_TICK_CYCLES   = SSRC_TICK_NS / SSRC_CLK_PERIOD_NS;
    localparam int unsigned SSRC_PRESC_W       = 15;

    // ============================================================
    // timing, in milliseconds (one tick each)
    localparam int unsigned SSRC_POWER_ON_WAIT_MS  = 1500;
    localparam int unsigned SSRC_AUTO_DETECT_MS    = 100;
    localparam int unsigned SSRC_MIN_PULSE_MS      = 80;
    localparam int unsigned SSRC_RESPONSE_MS       = 150;
    localparam int unsigned SSRC_ACT_AUTO_MS       = 1500;
    localparam int unsigned SSRC_ACT_MANUAL_MS     = 100;
    localparam int unsigned SSRC_UPTIME_W          = 11;
    localparam int unsigned SSRC_PULSE_W           = 7;

    // ============================================================
    // modes and run states
    typedef enum logic [1:0] {
        SSRC_MODE_NONE,
        SSRC_MODE_AUTO,
        SSRC_MODE_MANUAL,
        SSRC_MODE_MONITORED
    } ssrc_mode_t;

    typedef enum logic [1:0] {
        SSRC_ST_POWER_UP,
        SSRC_ST_DEENERGIZED,
        SSRC_ST_ENERGIZED,
        SSRC_ST_FAULT
    } ssrc_run_t;

    // ============================================================
    // input pins, all active high
    typedef struct packed {
        logic supply;
        logic am_start;
        logic mon_start;
    } ssrc_pins_t;

    localparam ssrc_pins_t SSRC_PINS_RST = 3'h0;

endpackage

// file: hdl/ssrc_sync.sv
// three-stage input synchroniser with agreement filter for the pin inputs
module ssrc_sync
    import ssrc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire ssrc_pins_t pins_raw,
    output ssrc_pins_t      pins_clean
);

    // ============================================================
    // state
    typedef struct packed {
        ssrc_pins_t s1;
        ssrc_pins_t s2;
        ssrc_pins_t s3;
        ssrc_pins_t clean;
    } ssrc_sync_state_t;

    ssrc_sync_state_t q;
    ssrc_sync_state_t d;

    // s1 is read only by s2; a bit moves only when s2 and s3 agree
    always_comb begin
        d       = q;
        d.s1    = pins_raw;
        d.s2    = q.s1;
        d.s3    = q.s2;
        d.clean = (q.s2 & q.s3) | (q.clean & (q.s2 ^ q.s3));
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= {SSRC_PINS_RST, SSRC_PINS_RST, SSRC_PINS_RST, SSRC_PINS_RST};
        end else begin
            q <= d;
        end
    end

    assign pins_clean = q.clean;

endmodule

// file: test/ssrc_top_assertions.sv
// port-level checks of the start/restart sequencer
module ssrc_top_assertions
    import ssrc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = SSRC_TICK_CYCLES
)
(
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic       safety_supply_input_pos,
    input wire logic       auto_manual_start_input,
    input wire logic       monitored_start_input,
    input wire logic       start_supply_output,
    input wire logic       safety_outputs_energized,
    input wire logic       fault_latched,
    input wire ssrc_mode_t start_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // properties; margins of 8 cycles cover the 3-stage pin filter
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_drop_on_loss: assert property (!safety_supply_input_pos [*8] |-> !safety_outputs_energized)
        else $error("outputs on after supply loss");
    chk_auto_on: assert property ((start_mode == SSRC_MODE_AUTO && safety_supply_input_pos
        && !fault_latched) [*8] |-> safety_outputs_energized)
        else $error("auto mode not energized");
    chk_mode_kept: assert property (start_mode != SSRC_MODE_NONE |=> $stable(start_mode))
        else $error("mode changed after selection");
    chk_mon_fall: assert property ($rose(safety_outputs_energized)
        && start_mode == SSRC_MODE_MONITORED |-> !monitored_start_input)
        else $error("monitored energize before falling edge");
    chk_man_press: assert property ($rose(safety_outputs_energized)
        && start_mode == SSRC_MODE_MANUAL |-> $past(auto_manual_start_input, 4))
        else $error("manual energize without press");
    chk_fault_safe: assert property (fault_latched
        |-> !safety_outputs_energized && !start_supply_output)
        else $error("fault without safe state");
    chk_fault_hold: assert property (fault_latched |=> fault_latched)
        else $error("fault released without power cycle");
    chk_supply_up: assert property ($fell(sys_rst) |-> ##[1:3] start_supply_output)
        else $error("start supply not raised");
endmodule

bind ssrc_top ssrc_top_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .sys_clk                  (sys_clk),
    .sys_rst                  (sys_rst),
    .safety_supply_input_pos  (safety_supply_input_pos),
    .auto_manual_start_input  (auto_manual_start_input),
    .monitored_start_input    (monitored_start_input),
    .start_supply_output      (start_supply_output),
    .safety_outputs_energized (safety_outputs_energized),
    .fault_latched            (fault_latched),
    .start_mode               (start_mode)
);

// file: test/ssrc_button.sv
// push-button partner on one start channel; an open contact reads low
module ssrc_button (
    input  wire logic sys_clk,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin = 1'b0;
    // whole cycles only; callers choose hold and power-on wait
    task automatic press(input int unsigned n);
        pin <= 1'b1;
        repeat (n) @(posedge sys_clk);
        pin <= 1'b0;
    endtask
endmodule

// file: test/ssrc_top_tb.sv
// self-checking bench of the start/restart sequencer, 1 ms = 10 cycles
module ssrc_top_tb;
    import ssrc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned TC = 10;
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       supply  = 1'b0;
    logic       am_tie  = 1'b0;
    logic       am_btn, mon_btn, ssup, en, flt;
    ssrc_mode_t mode;
    int         failures = 0;
    int         n_tests  = 0;
    int         cyc      = 0;
    int unsigned hold;

    always #20 sys_clk = ~sys_clk;

    ssrc_top #(.TICK_CYCLES(TC)) uut (
        .sys_clk                  (sys_clk),
        .sys_rst                  (sys_rst),
        .safety_supply_input_pos  (supply),
        .auto_manual_start_input  ((am_tie | am_btn) & ssup), // fed from start supply
        .monitored_start_input    (mon_btn),
        .start_supply_output      (ssup),
        .safety_outputs_energized (en),
        .fault_latched            (flt),
        .start_mode               (mode)
    );
    ssrc_button am_b (.sys_clk(sys_clk), .pin(am_btn));
    ssrc_button mon_b (.sys_clk(sys_clk), .pin(mon_btn));

    // ============================================================
    // tasks
    task automatic close_out();
        if (failures == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t bit %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chkm(input ssrc_mode_t got, input ssrc_mode_t exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t mode %0d exp %0d", $time, got, exp);
        end
    endtask
    // a monitored pulse counts once it has stood for the minimum width
    function automatic logic pulse_ok(input int unsigned n);
        return n >= SSRC_MIN_PULSE_MS * TC;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // bounded wait; sampled after the edge so the outputs have settled
    task automatic wait_en(input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge sys_clk);
            #1;
            if (en === v) break;
        end
        chk1(en, v);
        @(posedge sys_clk);
    endtask
    task automatic por(input logic am);
        sys_rst <= 1'b1;
        am_tie  <= am;
        supply  <= 1'b1;
        tick(20);
        sys_rst <= 1'b0;
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            close_out();
        end
    end

    // ============================================================
    // scenarios
    initial begin
        void'($urandom(36));
        por(1'b1);
        wait_en(1'b1, TC * 1500);
        chkm(mode, SSRC_MODE_AUTO);
        chk1(ssup, 1'b1);
        supply <= 1'b0;
        wait_en(1'b0, TC * 150);
        tick($urandom_range(200, 10));
        supply <= 1'b1;
        wait_en(1'b1, TC * 1500);

        por(1'b0);
        tick(TC * 200);
        chk1(en, 1'b0);
        fork am_b.press($urandom_range(400, 200)); join_none
        wait_en(1'b1, TC * 100);
        chkm(mode, SSRC_MODE_MANUAL);
        tick(400);
        chk1(en, 1'b1);
        supply <= 1'b0;
        wait_en(1'b0, TC * 150);
        supply <= 1'b1;
        tick(TC * 150);
        chk1(en, 1'b0);
        fork am_b.press($urandom_range(400, 200)); join_none
        wait_en(1'b1, TC * 100);
        tick(400);

        por(1'b0);
        tick(TC * 1510);
        hold = TC * $urandom_range(70, 20);
        mon_b.press(hold);
        tick(TC * 150);
        chk1(en, pulse_ok(hold));
        chkm(mode, SSRC_MODE_MONITORED);
        hold = TC * $urandom_range(120, 82);
        mon_b.press(hold);
        chk1(en, 1'b0);
        wait_en(pulse_ok(hold), TC * 100);
        supply <= 1'b0;
        wait_en(1'b0, TC * 150);

        por(1'b1);
        mon_b.press(TC * 200);
        chk1(flt, 1'b1);
        chk1(en, 1'b0);
        tick(TC * 50);
        chk1(flt, 1'b1);
        chk1(ssup, 1'b0);
        close_out();
    end
endmodule
